/* File: inc/bpds_defs.svh */
`ifndef BPDS_DEFS_SVH
`define BPDS_DEFS_SVH

// Register byte offsets on the APB.
`define BPDS_OFS_CTRL      8'h00
`define BPDS_OFS_SHDN      8'h04
`define BPDS_OFS_RSTR      8'h08
`define BPDS_OFS_STAT      8'h0C

// Reset values.
`define BPDS_CTRL_RST      6'h00
`define BPDS_SHDN_RST      7'h00
`define BPDS_SHIFT_RST     3'h0

// Control register fields.
`define BPDS_CTRL_DIR      0
`define BPDS_CTRL_POL_AC   1
`define BPDS_CTRL_POL_BD   2
`define BPDS_CTRL_FB_EN    3
`define BPDS_CTRL_DRV_EN   4
`define BPDS_CTRL_COMPARATOR_TWO_SYNC   5
`define BPDS_CTRL_MSB      5

// Auto-shutdown control register fields.
`define BPDS_SHDN_STATUS   7
`define BPDS_SHDN_SRC_HI   6
`define BPDS_SHDN_SRC_LO   4
`define BPDS_SHDN_AC_HI    3
`define BPDS_SHDN_AC_LO    2
`define BPDS_SHDN_BD_HI    1
`define BPDS_SHDN_BD_LO    0
`define BPDS_SRC_CMP1      0
`define BPDS_SRC_CMP2      1
`define BPDS_SRC_PIN       2

// Restart register field.
`define BPDS_RSTR_AUTO     7

// Status register fields.
`define BPDS_STAT_TMR_HI   7
`define BPDS_STAT_TMR_LO   0
`define BPDS_STAT_DIR      8
`define BPDS_STAT_COND     9
`define BPDS_STAT_PFLAG    10

// Timer counts before the period end at which a direction change begins.
`define BPDS_DIR_LEAD      9'h004

// Shutdown pair codes.
`define BPDS_PSS_LOW       2'h0
`define BPDS_PSS_HIGH      2'h1
`define BPDS_PSS_TRI_BIT   1

`endif

/* File: inc/bpds_pkg.sv */
package bpds_pkg;

  // Time base from the neighbouring period and duty logic.
  typedef struct packed {
    logic [7:0] count;
    logic [7:0] period;
    logic       start;
    logic       duty;
  } bpds_timebase_type;

  // One bridge pin: level and active-low output enable.
  typedef struct packed {
    logic out;
    logic oe_n;
  } bpds_pin_type;

  // Direction sequencer states.
  typedef enum logic {
    DIR_STEADY,
    DIR_BLANK
  } bpds_dir_state_type;

endpackage

/* File: core/bpds_top.sv */
// Overview of operation
// - In full-bridge mode one direction bit selects forward or reverse operation.
// - A direction change takes effect at the next PWM cycle, never immediately.
// - On a pending change, B and D go inactive four timer counts before period end.
// - At that same moment A and C swap to drive the opposite direction.
// - Modulation of the new output restarts at the start of the next period.
// - No dead-band delay is inserted in either full-bridge direction.
// - Two polarity bits make pair A/C and pair B/D active-high or active-low.
// - A three-bit field selects comparator one, comparator two and the pin, in any mix.
// - A firmware write of one to the shutdown status bit is a shutdown event.
// - A shutdown event sets the status bit until firmware or auto-restart clears it.
// - A shutdown event places every enabled pin in its shutdown state at once.
// - Pair A/C shutdown field: 00 low, 01 high, 1x high-impedance.
// - Pair B/D shutdown field: 00 low, 01 high, 1x high-impedance.
// - The shutdown condition is level-sensitive and lasts while the source level stays.
// - Firmware writes to the status bit are ignored while the condition persists.
// - After the condition clears and a restart, output resumes at the next period start.
// - With auto-restart, status stays set during the condition, then clears by itself.
// - With the sync option, comparator two shutdown waits for the secondary timer.
// - Forward: A active, D modulated, B and C inactive; reverse mirrors with C and B.
// - The auto-restart bit picks hardware clearing or firmware clearing of the status bit.
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "bpds_defs.svh"

module bpds_top #(
  parameter int SYNC_N = 3
) (
  // Clock and reset.
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // APB slave.
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [7:0]                 paddr,
  input  wire logic [31:0]                pwdata,
  output var  logic [31:0]                prdata,
  output var  logic                       pready,
  output var  logic                       pslverr,
  // Time base from the period logic, same clock.
  input  wire bpds_pkg::bpds_timebase_type tbase,
  input  wire logic                       sec_timer_tick,
  // Shutdown sources from outside the clock domain.
  input  wire logic                       comparator_one,
  input  wire logic                       comparator_two,
  input  wire logic                       ext_int_n,
  // Bridge pins.
  output var  bpds_pkg::bpds_pin_type     bridge_out_a,
  output var  bpds_pkg::bpds_pin_type     bridge_out_b,
  output var  bpds_pkg::bpds_pin_type     bridge_out_c,
  output var  bpds_pkg::bpds_pin_type     bridge_out_d
);

  // The filter compares the last two stages, so at least three are needed.
  if (SYNC_N < 3) begin : g_bad_sync
    $error("SYNC_N must be at least 3.");
  end

  // Decodes one register address.
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
    reg_hit = (addr == ofs);
  endfunction

  // Drives one pin in normal or shutdown state.
  function automatic bpds_pkg::bpds_pin_type pin_drive(input logic       level,
                                                        input logic       shut,
                                                        input logic [1:0] pss,
                                                        input logic       drv);
    bpds_pkg::bpds_pin_type p;
    p.out  = 1'b0;
    p.oe_n = 1'b1;
    if (drv && shut) begin
      p.out  = (pss == `BPDS_PSS_HIGH);
      p.oe_n = pss[`BPDS_PSS_TRI_BIT];
    end else if (drv) begin
      p.out  = level;
      p.oe_n = 1'b0;
    end
    pin_drive = p;
  endfunction

  logic [`BPDS_CTRL_MSB:0]       ctrl_q;
  logic [`BPDS_SHDN_SRC_HI:0]    shdn_cfg_q;
  logic                          auto_restart_q;
  logic                          status_q;
  logic                          status_d;
  logic                          resume_wait_q;
  logic                          pflag_q;
  logic                          run_q;
  logic                          dir_app_q;
  logic                          c2_gate_q;
  bpds_pkg::bpds_dir_state_type  dst_q;
  logic [2:0]                    filt_q;
  logic [2:0]                    async_in;
  logic                          wr_acc;
  logic                          fw_set;
  logic                          fw_clr;
  logic                          cond;
  logic                          c2_eff;
  logic                          early;
  logic                          pending;
  logic                          shut_now;
  logic                          mod;
  logic                          lvl_a;
  logic                          lvl_b;
  logic                          lvl_c;
  logic                          lvl_d;
  logic                          drv_en;
  logic                          pol_ac;
  logic                          pol_bd;
  logic [2:0]                    src;
  logic [1:0]                    pss_ac;
  logic [1:0]                    pss_bd;

  assign async_in = {ext_int_n, comparator_two, comparator_one};

  // Three-stage synchronisers reset to each source's idle level, so no false event follows reset.
  // A level is taken once the last two stages agree.
  for (genvar i = 0; i < 3; i++) begin : g_sync
    logic [SYNC_N-1:0] sync_q;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sync_q <= {SYNC_N{(i == `BPDS_SRC_PIN)}};
      end else begin
        sync_q <= {sync_q[SYNC_N-2:0], async_in[i]};
      end
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        filt_q[i] <= (i == `BPDS_SRC_PIN);
      end else if (sync_q[SYNC_N-1] == sync_q[SYNC_N-2]) begin
        filt_q[i] <= sync_q[SYNC_N-1];
      end
    end
  end

  // Field views and the APB write strobes.
  assign drv_en  = ctrl_q[`BPDS_CTRL_DRV_EN];
  assign pol_ac  = ctrl_q[`BPDS_CTRL_POL_AC];
  assign pol_bd  = ctrl_q[`BPDS_CTRL_POL_BD];
  assign src     = shdn_cfg_q[`BPDS_SHDN_SRC_HI:`BPDS_SHDN_SRC_LO];
  assign pss_ac  = shdn_cfg_q[`BPDS_SHDN_AC_HI:`BPDS_SHDN_AC_LO];
  assign pss_bd  = shdn_cfg_q[`BPDS_SHDN_BD_HI:`BPDS_SHDN_BD_LO];
  assign wr_acc  = psel && penable && pwrite && pready;
  assign fw_set  = wr_acc && reg_hit(paddr, `BPDS_OFS_SHDN) && pwdata[`BPDS_SHDN_STATUS];
  assign fw_clr  = wr_acc && reg_hit(paddr, `BPDS_OFS_SHDN) && !pwdata[`BPDS_SHDN_STATUS];

  // Comparator two passes only on a secondary timer tick when sync is on.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c2_gate_q <= 1'b0;
    end else if (sec_timer_tick) begin
      c2_gate_q <= filt_q[`BPDS_SRC_CMP2];
    end
  end
  assign c2_eff = ctrl_q[`BPDS_CTRL_COMPARATOR_TWO_SYNC] ? c2_gate_q : filt_q[`BPDS_SRC_CMP2];

  // Selected sources ORed into one level condition.
  assign cond = (src[`BPDS_SRC_CMP1] && filt_q[`BPDS_SRC_CMP1])
             || (src[`BPDS_SRC_CMP2] && c2_eff)
             || (src[`BPDS_SRC_PIN] && !filt_q[`BPDS_SRC_PIN]);

  // Next shutdown status: the condition wins over any clear.
  always_comb begin
    if (cond || fw_set) begin
      status_d = 1'b1;
    end else if (auto_restart_q || fw_clr) begin
      status_d = 1'b0;
    end else begin
      status_d = status_q;
    end
  end

  // Shutdown status register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= 1'b0;
    end else begin
      status_q <= status_d;
    end
  end

  // After a restart the pins keep their shutdown state until a new period.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resume_wait_q <= 1'b0;
    end else if (status_q && !status_d) begin
      resume_wait_q <= 1'b1;
    end else if (tbase.start) begin
      resume_wait_q <= 1'b0;
    end
  end

  // Modulation starts only at a period start, so no partial pulse appears.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 1'b0;
    end else if (!ctrl_q[`BPDS_CTRL_FB_EN]) begin
      run_q <= 1'b0;
    end else if (tbase.start) begin
      run_q <= 1'b1;
    end
  end

  assign pending = ctrl_q[`BPDS_CTRL_DIR] != dir_app_q;
  assign early   = ({1'b0, tbase.count} + `BPDS_DIR_LEAD) == {1'b0, tbase.period};

  // Direction sequencer: switch A/C and blank B/D early, resume at next period.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dst_q     <= bpds_pkg::DIR_STEADY;
      dir_app_q <= 1'b0;
    end else if (!run_q) begin
      dst_q     <= bpds_pkg::DIR_STEADY;
      dir_app_q <= ctrl_q[`BPDS_CTRL_DIR];
    end else begin
      unique case (dst_q)
        bpds_pkg::DIR_STEADY: begin
          if (pending && early) begin
            dst_q     <= bpds_pkg::DIR_BLANK;
            dir_app_q <= ctrl_q[`BPDS_CTRL_DIR];
          end
        end
        bpds_pkg::DIR_BLANK: begin
          if (tbase.start) begin
            dst_q <= bpds_pkg::DIR_STEADY;
          end
        end
      endcase
    end
  end

  // Active-high bridge levels; A/C and B/D change on the same edge, no dead band.
  assign mod   = tbase.duty && run_q && (dst_q == bpds_pkg::DIR_STEADY);
  assign lvl_a = run_q && !dir_app_q;
  assign lvl_c = run_q && dir_app_q;
  assign lvl_d = mod && !dir_app_q;
  assign lvl_b = mod && dir_app_q;
  assign shut_now = status_q || status_d || resume_wait_q;

  // Pin registers: polarity first, then shutdown override.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bridge_out_a <= '{out: 1'b0, oe_n: 1'b1};
      bridge_out_b <= '{out: 1'b0, oe_n: 1'b1};
      bridge_out_c <= '{out: 1'b0, oe_n: 1'b1};
      bridge_out_d <= '{out: 1'b0, oe_n: 1'b1};
    end else begin
      bridge_out_a <= pin_drive(lvl_a ^ pol_ac, shut_now, pss_ac, drv_en);
      bridge_out_c <= pin_drive(lvl_c ^ pol_ac, shut_now, pss_ac, drv_en);
      bridge_out_b <= pin_drive(lvl_b ^ pol_bd, shut_now, pss_bd, drv_en);
      bridge_out_d <= pin_drive(lvl_d ^ pol_bd, shut_now, pss_bd, drv_en);
    end
  end

  // Configuration registers written at the APB access edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q         <= `BPDS_CTRL_RST;
      shdn_cfg_q     <= `BPDS_SHDN_RST;
      auto_restart_q <= 1'b0;
    end else if (wr_acc) begin
      if (reg_hit(paddr, `BPDS_OFS_CTRL)) begin
        ctrl_q <= pwdata[`BPDS_CTRL_MSB:0];
      end
      if (reg_hit(paddr, `BPDS_OFS_SHDN)) begin
        shdn_cfg_q <= pwdata[`BPDS_SHDN_SRC_HI:0];
      end
      if (reg_hit(paddr, `BPDS_OFS_RSTR)) begin
        auto_restart_q <= pwdata[`BPDS_RSTR_AUTO];
      end
    end
  end

  // Period flag: set at each period start, write one to clear; the set wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pflag_q <= 1'b0;
    end else if (tbase.start) begin
      pflag_q <= 1'b1;
    end else if (wr_acc && reg_hit(paddr, `BPDS_OFS_STAT) && pwdata[`BPDS_STAT_PFLAG]) begin
      pflag_q <= 1'b0;
    end
  end

  // APB answer: read data and ready are prepared in the setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (psel && !penable) begin
      pready  <= 1'b1;
      pslverr <= !(reg_hit(paddr, `BPDS_OFS_CTRL) || reg_hit(paddr, `BPDS_OFS_SHDN)
                || reg_hit(paddr, `BPDS_OFS_RSTR) || reg_hit(paddr, `BPDS_OFS_STAT));
      prdata  <= 32'h0000_0000;
      if (!pwrite && reg_hit(paddr, `BPDS_OFS_CTRL)) begin
        prdata[`BPDS_CTRL_MSB:0] <= ctrl_q;
      end
      if (!pwrite && reg_hit(paddr, `BPDS_OFS_SHDN)) begin
        prdata[`BPDS_SHDN_STATUS]     <= status_q;
        prdata[`BPDS_SHDN_SRC_HI:0]   <= shdn_cfg_q;
      end
      if (!pwrite && reg_hit(paddr, `BPDS_OFS_RSTR)) begin
        prdata[`BPDS_RSTR_AUTO] <= auto_restart_q;
      end
      if (!pwrite && reg_hit(paddr, `BPDS_OFS_STAT)) begin
        prdata[`BPDS_STAT_TMR_HI:`BPDS_STAT_TMR_LO] <= tbase.count;
        prdata[`BPDS_STAT_DIR]   <= dir_app_q;
        prdata[`BPDS_STAT_COND]  <= cond;
        prdata[`BPDS_STAT_PFLAG] <= pflag_q;
      end
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Checks on the sequencer, the shutdown logic and the pins.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  dir_start_a: assert property (run_q && dst_q == bpds_pkg::DIR_STEADY && pending && early
    |=> dst_q == bpds_pkg::DIR_BLANK && dir_app_q == $past(ctrl_q[`BPDS_CTRL_DIR]))
    else $error("Direction change did not begin four counts before period end.");

  dir_wait_a: assert property (run_q && dst_q == bpds_pkg::DIR_STEADY && pending && !early
    |=> dir_app_q == $past(dir_app_q))
    else $error("Direction changed outside the early window.");

  blank_resume_a: assert property (run_q && dst_q == bpds_pkg::DIR_BLANK && tbase.start
    |=> dst_q == bpds_pkg::DIR_STEADY)
    else $error("Modulation did not resume at the period start.");

  blank_pins_a: assert property (dst_q == bpds_pkg::DIR_BLANK && !shut_now && drv_en
    |=> bridge_out_b.out == $past(pol_bd) && bridge_out_d.out == $past(pol_bd))
    else $error("Modulated outputs not inactive during blanking.");

  fwd_pins_a: assert property (run_q && !dir_app_q && !shut_now && drv_en
    |=> bridge_out_a.out != $past(pol_ac) && bridge_out_c.out == $past(pol_ac)
        && bridge_out_b.out == $past(pol_bd))
    else $error("Forward pin levels wrong.");

  shdn_set_a: assert property (cond |=> status_q [*1] ##1 (status_q || !$past(cond)))
    else $error("Shutdown condition did not set the status bit.");

  write_block_a: assert property (cond && fw_clr |=> status_q)
    else $error("Status write took effect during a shutdown condition.");

  auto_clear_a: assert property (status_q && auto_restart_q && !cond && !fw_set |=> !status_q)
    else $error("Auto-restart did not clear the status bit.");

  manual_hold_a: assert property (status_q && !auto_restart_q && !fw_clr |=> status_q)
    else $error("Status bit cleared without firmware.");

  restart_wait_a: assert property (resume_wait_q && !tbase.start && !status_d
    |=> resume_wait_q && bridge_out_a.oe_n == $past(!drv_en || pss_ac[`BPDS_PSS_TRI_BIT]))
    else $error("Pins resumed before the next period start.");

  shdn_low_a: assert property (status_d && drv_en && pss_ac == `BPDS_PSS_LOW
    |=> !bridge_out_a.out && !bridge_out_a.oe_n && !bridge_out_c.out)
    else $error("Pair A/C not driven low in shutdown.");

  shdn_tri_a: assert property (shut_now && pss_bd[`BPDS_PSS_TRI_BIT]
    |=> bridge_out_b.oe_n && bridge_out_d.oe_n)
    else $error("Pair B/D not released in shutdown.");

  src_off_a: assert property (src == 3'h0 |-> !cond)
    else $error("Disabled shutdown source raised a condition.");

  c2_sync_a: assert property (ctrl_q[`BPDS_CTRL_COMPARATOR_TWO_SYNC] && src == 3'h2 && !c2_gate_q |-> !cond)
    else $error("Comparator two bypassed the secondary timer.");

  dir_swap_c: cover property (dst_q == bpds_pkg::DIR_STEADY ##1 dst_q == bpds_pkg::DIR_BLANK);
  auto_restart_c: cover property (status_q && auto_restart_q ##1 !status_q ##[1:300] tbase.start);
  fw_shutdown_c: cover property (fw_set ##1 status_q);

endmodule // bpds_top

`default_nettype wire

/* File: sim/bpds_bridge_model.sv */
`timescale 1ns/100ps
`default_nettype none

module bpds_bridge_model #(
  parameter int PERIOD = 20,
  parameter int DUTY   = 10
) (
  // Clock and reset.
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // Time base handed to the bridge stage.
  output var  bpds_pkg::bpds_timebase_type tbase,
  // Bridge pins and the levels seen on the board.
  input  wire bpds_pkg::bpds_pin_type  pin_a,
  input  wire bpds_pkg::bpds_pin_type  pin_b,
  input  wire bpds_pkg::bpds_pin_type  pin_c,
  input  wire bpds_pkg::bpds_pin_type  pin_d,
  output var  logic [3:0]              pin_level
);
  logic [7:0] count_q;

  // The period timer counts up to the period value and wraps to zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= 8'h00;
    end else begin
      count_q <= (count_q == PERIOD[7:0]) ? 8'h00 : count_q + 8'h01;
    end
  end

  // Start pulses once per period; duty is high in the first part of it.
  always_comb begin
    tbase.count  = count_q;
    tbase.period = PERIOD[7:0];
    tbase.start  = (count_q == 8'h00);
    tbase.duty   = (count_q < DUTY[7:0]);
  end

  // The gate drivers see pull-downs, so a released pin reads low.
  always_comb begin
    pin_level[3] = pin_a.oe_n ? 1'b0 : pin_a.out;
    pin_level[2] = pin_b.oe_n ? 1'b0 : pin_b.out;
    pin_level[1] = pin_c.oe_n ? 1'b0 : pin_c.out;
    pin_level[0] = pin_d.oe_n ? 1'b0 : pin_d.out;
  end
endmodule // bpds_bridge_model

`default_nettype wire

/* File: sim/bpds_top_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "bpds_defs.svh"

module bpds_top_tb;
  logic                        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic                        sec_timer_tick, comparator_one, comparator_two, ext_int_n;
  logic [7:0]                  paddr;
  logic [31:0]                 pwdata, prdata;
  logic [3:0]                  pin_level;
  logic [32:0]                 exp_q[$];
  logic [3:0]                  pss;
  logic                        sel;
  int                          n_errors, checked;
  bpds_pkg::bpds_timebase_type tbase;
  bpds_pkg::bpds_pin_type      pa, pb, pc, pd;

  bpds_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tbase(tbase), .sec_timer_tick(sec_timer_tick), .comparator_one(comparator_one),
    .comparator_two(comparator_two), .ext_int_n(ext_int_n), .bridge_out_a(pa),
    .bridge_out_b(pb), .bridge_out_c(pc), .bridge_out_d(pd));

  bpds_bridge_model model_u (.pclk(pclk), .presetn(presetn), .tbase(tbase), .pin_a(pa),
    .pin_b(pb), .pin_c(pc), .pin_d(pd), .pin_level(pin_level));

  // The clock toggles every half period.
  always #5 pclk = ~pclk;

  // Compares a seen value with an expected one and counts the outcome.
  task automatic check(input logic [32:0] seen, input logic [32:0] expv);
    checked++;
    if (seen !== expv) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // One APB transfer; a read leaves its expected answer on the queue.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    if (!wr) exp_q.push_back(e);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // Waits for the edge at which the period timer holds the given count.
  task automatic at_count(input int k);
    do begin
      @(posedge pclk);
    end while (tbase.count !== k[7:0]);
    #1;
  endtask

  // Drives one shutdown source to its active or idle level.
  task automatic src(input int s, input logic on);
    @(posedge pclk);
    case (s)
      0: comparator_one <= on;
      1: comparator_two <= on;
      default: ext_int_n <= !on;
    endcase
  endtask

  // Shutdown level of one pin for a pair field, as {out, oe_n}.
  function automatic logic [1:0] lvl(input logic [1:0] p);
    return p[1] ? 2'b01 : {p[0], 1'b0};
  endfunction

  // Takes the oldest expectation whenever read data comes back.
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      check({pslverr, prdata}, exp_q.pop_front());
    end
  end

  // Cuts a hung run short.
  initial begin
    #100us;
    n_errors++;
    finish_test;
  end

  // Main sequence.
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00; pwdata = 32'h0;
    sec_timer_tick = 0; comparator_one = 0; comparator_two = 0; ext_int_n = 1;
    n_errors = 0; checked = 0;
    void'($urandom(12));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and an unmapped place.
    apb(0, `BPDS_OFS_CTRL, 32'h0, 33'h0);
    apb(0, `BPDS_OFS_SHDN, 32'h0, 33'h0);
    apb(0, `BPDS_OFS_RSTR, 32'h0, 33'h0);
    apb(0, 8'h10, 32'h0, 33'h1_0000_0000);
    // Mode first, drivers only after a full period.
    apb(1, `BPDS_OFS_CTRL, 32'h08, 0);
    at_count(0);
    at_count(0);
    check({pa, pb, pc, pd}, 8'h55);
    apb(1, `BPDS_OFS_CTRL, 32'h18, 0);
    at_count(2);
    check({pa, pb, pc, pd}, 8'h82);
    // Reversal written mid-period waits for the early window.
    at_count(5);
    apb(1, `BPDS_OFS_CTRL, 32'h19, 0);
    at_count(15);
    check({pa, pb, pc, pd}, 8'h80);
    at_count(17);
    check({pa, pb, pc, pd}, 8'h08);
    at_count(2);
    check({pa, pb, pc, pd}, 8'h28);
    // Polarity set while the drivers are off.
    apb(1, `BPDS_OFS_CTRL, 32'h09, 0);
    apb(1, `BPDS_OFS_CTRL, 32'h0F, 0);
    apb(1, `BPDS_OFS_CTRL, 32'h1F, 0);
    at_count(15);
    check({pa, pb, pc, pd}, 8'hA2);
    apb(1, `BPDS_OFS_CTRL, 32'h18, 0);
    // Every source code against every source, with random pair levels.
    for (int code = 0; code < 8; code++) begin
      for (int s = 0; s < 3; s++) begin
        pss = 4'($urandom);
        sel = code[s];
        apb(1, `BPDS_OFS_SHDN, {25'h0, code[2:0], pss}, 0);
        src(s, 1'b1);
        repeat (8) @(posedge pclk);
        apb(0, `BPDS_OFS_SHDN, 0, {25'h0, sel, code[2:0], pss});
        #1;
        if (sel) check({pa, pc, pb, pd}, {lvl(pss[3:2]), lvl(pss[3:2]), lvl(pss[1:0]), lvl(pss[1:0])});
        if (sel) check(pin_level, {2{!pss[3] && pss[2], !pss[1] && pss[0]}});
        apb(1, `BPDS_OFS_SHDN, {25'h0, code[2:0], pss}, 0);
        apb(0, `BPDS_OFS_SHDN, 0, {25'h0, sel, code[2:0], pss});
        src(s, 1'b0);
        repeat (8) @(posedge pclk);
        apb(1, `BPDS_OFS_SHDN, 32'h0, 0);
      end
    end
    // Firmware shutdown, then firmware restart at the next period.
    at_count(3);
    apb(1, `BPDS_OFS_SHDN, 32'h85, 0);
    apb(0, `BPDS_OFS_SHDN, 0, 33'h85);
    #1;
    check({pa, pb, pc, pd}, 8'hAA);
    apb(1, `BPDS_OFS_SHDN, 32'h05, 0);
    #1;
    check({pa, pb, pc, pd}, 8'hAA);
    at_count(2);
    check({pa, pb, pc, pd}, 8'h82);
    // Automatic restart clears the status once the source goes away.
    apb(1, `BPDS_OFS_RSTR, 32'h80, 0);
    apb(1, `BPDS_OFS_SHDN, 32'h10, 0);
    src(0, 1'b1);
    repeat (8) @(posedge pclk);
    apb(0, `BPDS_OFS_SHDN, 0, 33'h90);
    src(0, 1'b0);
    repeat (8) @(posedge pclk);
    apb(0, `BPDS_OFS_SHDN, 0, 33'h10);
    // Comparator two waits for the secondary timer when synchronised.
    apb(1, `BPDS_OFS_CTRL, 32'h38, 0);
    apb(1, `BPDS_OFS_SHDN, 32'h20, 0);
    src(1, 1'b1);
    repeat (10) @(posedge pclk);
    apb(0, `BPDS_OFS_SHDN, 0, 33'h20);
    @(posedge pclk);
    sec_timer_tick <= 1'b1;
    @(posedge pclk);
    sec_timer_tick <= 1'b0;
    repeat (6) @(posedge pclk);
    apb(0, `BPDS_OFS_SHDN, 0, 33'hA0);
    src(1, 1'b0);
    repeat (8) @(posedge pclk);
    apb(0, `BPDS_OFS_SHDN, 0, 33'hA0);
    sec_timer_tick <= 1'b1;
    @(posedge pclk);
    sec_timer_tick <= 1'b0;
    repeat (6) @(posedge pclk);
    apb(0, `BPDS_OFS_SHDN, 0, 33'h20);
    repeat (4) @(posedge pclk);
    finish_test;
  end
endmodule // bpds_top_tb

`default_nettype wire
